// ---- rtl/vpo_pkg.sv ----
/*
  Constants and carrier types for the video port output formatter.
  Assumes one line-locked clock domain at the port and a system clock domain for settings.
*/
package vpo_pkg;
  localparam logic [7:0]  OFS_LINE_TYPE_FIRST = 8'h41;
  localparam logic [7:0]  OFS_LINE_TYPE_LAST  = 8'h57;
  localparam logic [7:0]  OFS_VOFF_LO         = 8'h5a;
  localparam logic [7:0]  OFS_VOFF_HI         = 8'h5b;
  localparam logic [7:0]  OFS_FORMAT          = 8'h10;
  localparam logic [7:0]  OFS_BYPASS          = 8'h11;
  localparam logic [7:0]  OFS_ADC_ALIGN       = 8'h13;
  localparam logic [7:0]  OFS_MODE            = 8'h02;
  localparam logic [7:0]  OFS_HSB             = 8'h06;
  localparam logic [7:0]  OFS_HSS             = 8'h07;
  localparam logic [7:0]  OFS_LUMA_BYPASS     = 8'h09;
  localparam int          BIT_VOFF_MSB        = 4;
  localparam int          BIT_FMT_HI          = 7;
  localparam int          BIT_FMT_LO          = 6;
  localparam int          BIT_VREF_LENGTH_SELECT            = 3;
  localparam int          BIT_BYPASS          = 1;
  localparam int          BIT_ALIGN           = 7;
  localparam int          BIT_LUMA_BYPASS     = 7;
  localparam logic [7:0]  RESET_BYTE          = 8'h00;
  localparam int          ACTIVE_CYCLES       = 1440;
  localparam int          LINE_CYCLES         = 1728;
  localparam int          ENTRY_FIRST         = 2;
  localparam int          ENTRY_LAST          = 24;
  localparam logic [7:0]  BLANK_A             = 8'h80;
  localparam logic [7:0]  BLANK_B             = 8'h10;
  localparam logic [7:0]  NO_DATA             = 8'h00;
  localparam logic [3:0]  TYPE_TEST           = 4'h6;
  localparam logic [3:0]  TYPE_RAW            = 4'h7;
  localparam logic [3:0]  TYPE_RESERVED       = 4'hb;
  localparam logic [3:0]  TYPE_ACTIVE         = 4'hf;

  typedef enum logic [1:0] {
    FMT_SLICED = 2'b00,
    FMT_YUV    = 2'b01,
    FMT_RAW    = 2'b10,
    FMT_NONE   = 2'b11
  } format_type;

  typedef struct packed {
    logic       bypass;
    logic       align_hi;
    logic       yc_mode;
    logic [1:0] v_format;
    logic       vref_length;
    logic [8:0] voffset;
    logic [7:0] hsync_begin;
    logic [7:0] hsync_stop;
    logic [1:0] hdelay;
  } settings_type;

  typedef struct packed {
    logic [7:0] yuv;
    logic [7:0] sliced;
    logic       sliced_valid;
    logic [7:0] raw;
    logic [8:0] adc_a;
    logic [8:0] adc_b;
  } sources_type;
endpackage

// ---- rtl/video_port_output_formatter.sv ----
/*
  Video port output formatter: picks a data type per line, frames it with timing codes.
  Assumes register writes arrive on clk, data sources and line timing on the line clock.
*/
// Summary of operation
// - Eight-bit port carries sixteen selectable data types.
// - Type code decides sliced, YUV or raw format.
// - Entries two to twenty-three program lines individually.
// - Last entry covers all remaining field lines.
// - Upper nibble field one, lower nibble field two.
// - Nine-bit vertical offset shifts entry line mapping.
// - Active video type outputs 720 YUV pixels.
// - Test line disables vertical filter, optional bypass.
// - Test line only where vertical reference zero.
// - Raw samples windowed by begin, stop, delay.
// - Bypass bit overrides table, outputs ADC data.
// - Bypass selects upper or lower ADC byte.
// - Bypass muxes ADCs in YC, no codes.
// - Code bit7 one, bit6 field, protection bits.
// - Bit5 is vertical blanking flag.
// - Bit4 zero in SAV, one in EAV.
// - Non-raw active region lasts 1440 cycles.
// - Invalid sliced cycles are sent as 00H.
// - Blanking sends alternating 80 and 10.
// - V bit from format bits, length, table.
// - F and V change only at EAV.
// - Table V mode: types 0-14 one, 15 zero.
`timescale 1ns/1ps
`default_nettype none
module video_port_output_formatter #(
  parameter int LINES_60 = 525
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  reg_write,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  line_locked_clock,
  input  wire logic                  link_rst,
  input  wire logic                  lines_625,
  input  wire vpo_pkg::sources_type  sources,
  output logic      [7:0]            video_port_output,
  output logic                       test_line_active,
  output logic                       test_line_luma_bypass
);
  logic [7:0] table_mem [vpo_pkg::ENTRY_FIRST:vpo_pkg::ENTRY_LAST];
  logic [7:0]            reg_voff_lo;
  logic [7:0]            reg_voff_hi;
  logic [7:0]            reg_fmt;
  logic [7:0]            reg_byp;
  logic [7:0]            reg_align;
  logic [7:0]            reg_mode;
  logic [7:0]            reg_hsb;
  logic [7:0]            reg_hss;
  logic [7:0]            reg_luma;
  logic [7:0]            next_rdata;
  vpo_pkg::settings_type cfg;
  vpo_pkg::settings_type cfg_s1;
  vpo_pkg::settings_type cfg_s2;
  logic [7:0] tbl_s1 [vpo_pkg::ENTRY_FIRST:vpo_pkg::ENTRY_LAST];
  logic [7:0] tbl_s2 [vpo_pkg::ENTRY_FIRST:vpo_pkg::ENTRY_LAST];

  // Read data is registered, so a read answers one clock after the address is set.
  // Unmapped addresses read as zero rather than as stale data.
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      vpo_pkg::OFS_VOFF_LO:     next_rdata = reg_voff_lo;
      vpo_pkg::OFS_VOFF_HI:     next_rdata = reg_voff_hi;
      vpo_pkg::OFS_FORMAT:      next_rdata = reg_fmt;
      vpo_pkg::OFS_BYPASS:      next_rdata = reg_byp;
      vpo_pkg::OFS_ADC_ALIGN:   next_rdata = reg_align;
      vpo_pkg::OFS_MODE:        next_rdata = reg_mode;
      vpo_pkg::OFS_HSB:         next_rdata = reg_hsb;
      vpo_pkg::OFS_HSS:         next_rdata = reg_hss;
      vpo_pkg::OFS_LUMA_BYPASS: next_rdata = reg_luma;
      default: begin
        if (reg_addr >= vpo_pkg::OFS_LINE_TYPE_FIRST && reg_addr <= vpo_pkg::OFS_LINE_TYPE_LAST) begin
          next_rdata = table_mem[int'(reg_addr - vpo_pkg::OFS_LINE_TYPE_FIRST) + vpo_pkg::ENTRY_FIRST];
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_voff_lo <= vpo_pkg::RESET_BYTE;
      reg_voff_hi <= vpo_pkg::RESET_BYTE;
      reg_fmt     <= vpo_pkg::RESET_BYTE;
      reg_byp     <= vpo_pkg::RESET_BYTE;
      reg_align   <= vpo_pkg::RESET_BYTE;
      reg_mode    <= vpo_pkg::RESET_BYTE;
      reg_hsb     <= vpo_pkg::RESET_BYTE;
      reg_hss     <= vpo_pkg::RESET_BYTE;
      reg_luma    <= vpo_pkg::RESET_BYTE;
      reg_rdata   <= 8'h00;
      for (int i = vpo_pkg::ENTRY_FIRST; i <= vpo_pkg::ENTRY_LAST; i++) begin
        table_mem[i] <= vpo_pkg::RESET_BYTE;
      end
    end else begin
      reg_rdata <= next_rdata;
      if (reg_write) begin
        case (reg_addr)
          vpo_pkg::OFS_VOFF_LO:     reg_voff_lo <= reg_wdata;
          vpo_pkg::OFS_VOFF_HI:     reg_voff_hi <= reg_wdata;
          vpo_pkg::OFS_FORMAT:      reg_fmt <= reg_wdata;
          vpo_pkg::OFS_BYPASS:      reg_byp <= reg_wdata;
          vpo_pkg::OFS_ADC_ALIGN:   reg_align <= reg_wdata;
          vpo_pkg::OFS_MODE:        reg_mode <= reg_wdata;
          vpo_pkg::OFS_HSB:         reg_hsb <= reg_wdata;
          vpo_pkg::OFS_HSS:         reg_hss <= reg_wdata;
          vpo_pkg::OFS_LUMA_BYPASS: reg_luma <= reg_wdata;
          default: begin
            if (reg_addr >= vpo_pkg::OFS_LINE_TYPE_FIRST && reg_addr <= vpo_pkg::OFS_LINE_TYPE_LAST) begin
              table_mem[int'(reg_addr - vpo_pkg::OFS_LINE_TYPE_FIRST) + vpo_pkg::ENTRY_FIRST] <= reg_wdata;
            end
          end
        endcase
      end
    end
  end

  always_comb begin
    cfg.bypass      = reg_byp[vpo_pkg::BIT_BYPASS];
    cfg.align_hi    = reg_align[vpo_pkg::BIT_ALIGN];
    cfg.yc_mode     = reg_mode[3];
    cfg.v_format    = {reg_fmt[vpo_pkg::BIT_FMT_HI], reg_fmt[vpo_pkg::BIT_FMT_LO]};
    cfg.vref_length = reg_fmt[vpo_pkg::BIT_VREF_LENGTH_SELECT];
    cfg.voffset     = {reg_voff_hi[vpo_pkg::BIT_VOFF_MSB], reg_voff_lo};
    cfg.hsync_begin = reg_hsb;
    cfg.hsync_stop  = reg_hss;
    cfg.hdelay      = reg_fmt[1:0];
  end

  // Settings are quasi-static; two flops per bit suffice, a line may see a mixed update.
  always_ff @(posedge line_locked_clock) begin
    cfg_s1 <= cfg;
    cfg_s2 <= cfg_s1;
    tbl_s1 <= table_mem;
    tbl_s2 <= tbl_s1;
  end

  logic                  lines_625_s1;
  logic                  lines_625_s2;

  // The standard select comes from outside; only the second flop is read.
  always_ff @(posedge line_locked_clock) begin
    lines_625_s1 <= lines_625;
    lines_625_s2 <= lines_625_s1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      test_line_luma_bypass <= 1'b0;
    end else begin
      test_line_luma_bypass <= reg_luma[vpo_pkg::BIT_LUMA_BYPASS];
    end
  end

  logic [10:0] hcount;
  logic [10:0] next_hcount;
  logic [9:0]  line;
  logic [9:0]  next_line;
  logic        field;
  logic        next_field;
  logic        vblank;
  logic        next_vblank;
  logic        line_vref;
  logic        next_line_vref;
  logic [3:0]  line_code;
  logic [3:0]  next_line_code;
  logic [7:0]  out_byte;
  logic [7:0]  next_out_byte;
  logic        tl_out;
  logic        next_tl_out;
  logic [9:0]  total_lines;
  logic [10:0] raw_start;
  logic [10:0] raw_end;

  function automatic logic [3:0] pick_type(input logic [9:0] ln, input logic fld);
    logic [9:0] rel;
    logic [7:0] entry;
    int         idx;
    // A line numbered below the offset wraps to a large value and so falls to the last entry.
    rel = ln - {1'b0, cfg_s2.voffset};
    idx = (rel >= 10'd22) ? vpo_pkg::ENTRY_LAST : int'(rel) + vpo_pkg::ENTRY_FIRST;
    entry = tbl_s2[idx];
    pick_type = fld ? entry[3:0] : entry[7:4];
  endfunction

  function automatic vpo_pkg::format_type fmt_of(input logic [3:0] t);
    if (t == vpo_pkg::TYPE_RESERVED) fmt_of = vpo_pkg::FMT_NONE;
    else if (t == vpo_pkg::TYPE_RAW) fmt_of = vpo_pkg::FMT_RAW;
    else if (t == vpo_pkg::TYPE_TEST || t == vpo_pkg::TYPE_ACTIVE) fmt_of = vpo_pkg::FMT_YUV;
    else fmt_of = vpo_pkg::FMT_SLICED;
  endfunction

  // Protection bits let a receiver correct a single flipped flag bit.
  // They are derived, never stored, so they cannot disagree with F, V and H.
  function automatic logic [7:0] trs(input logic f, input logic v, input logic h);
    trs = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction

  logic       itu_f;
  logic       itu_v;
  logic       ref_v;
  logic       tbl_v;
  logic       sel_v;
  logic [3:0] eff_type;
  vpo_pkg::format_type fmt;
  logic [8:0] adc_word;

  always_comb begin
    total_lines = lines_625_s2 ? 10'd625 : 10'(LINES_60);
    if (lines_625_s2) begin
      itu_f = (line >= 10'd313);
      itu_v = (line <= 10'd22) || (line >= 10'd311 && line <= 10'd335) || (line >= 10'd624);
      ref_v = itu_v || line == 10'd23 || line == 10'd310 || line == 10'd336 || line == 10'd623;
      if (cfg_s2.vref_length) ref_v = itu_v;
    end else begin
      itu_f = (line <= 10'd3) || (line >= 10'd266);
      itu_v = (line <= 10'd19) || (line >= 10'd264 && line <= 10'd282);
      ref_v = (line <= 10'd21) || (line >= 10'd262 && line <= 10'd284) || line == 10'd525;
      if (cfg_s2.vref_length) ref_v = itu_v || line == 10'd20 || line == 10'd263 || line == 10'd283;
    end
    tbl_v = (pick_type(line, itu_f) != vpo_pkg::TYPE_ACTIVE);
    case (cfg_s2.v_format)
      2'b00:   sel_v = itu_v;
      2'b01:   sel_v = ref_v;
      2'b10:   sel_v = tbl_v;
      default: sel_v = itu_v;
    endcase
  end

  always_comb begin
    // A test line on a line with the reference set is sent empty, like a reserved type.
    eff_type = line_code;
    if (line_code == vpo_pkg::TYPE_TEST && line_vref) eff_type = vpo_pkg::TYPE_RESERVED;
    fmt = fmt_of(eff_type);
    raw_start = 11'({cfg_s2.hsync_begin, 1'b0}) + 11'(cfg_s2.hdelay);
    raw_end   = 11'({cfg_s2.hsync_stop, 2'b00});
    adc_word = hcount[0] && cfg_s2.yc_mode ? sources.adc_b : sources.adc_a;
    next_hcount = hcount + 11'd1;
    next_line = line;
    next_field = field;
    next_vblank = vblank;
    next_line_code = line_code;
    next_line_vref = line_vref;
    next_tl_out = 1'b0;
    next_out_byte = (hcount[0]) ? vpo_pkg::BLANK_B : vpo_pkg::BLANK_A;
    if (hcount == 11'(vpo_pkg::LINE_CYCLES - 1)) begin
      next_hcount = 11'd0;
      next_line = (line == total_lines) ? 10'd1 : line + 10'd1;
    end
    if (cfg_s2.bypass) begin
      next_out_byte = cfg_s2.align_hi ? adc_word[8:1] : adc_word[7:0];
    end else if (hcount < 11'd4) begin
      case (hcount[1:0])
        2'd0:    next_out_byte = 8'hff;
        2'd3:    next_out_byte = trs(field, vblank, 1'b1);
        default: next_out_byte = 8'h00;
      endcase
      if (hcount == 11'd3) begin
        next_line_vref = ref_v;
        next_field = itu_f;
        next_vblank = sel_v;
        next_line_code = pick_type(line, itu_f);
      end
    end else if (hcount >= 11'(vpo_pkg::LINE_CYCLES - 4 - vpo_pkg::ACTIVE_CYCLES)
                 && hcount < 11'(vpo_pkg::LINE_CYCLES - vpo_pkg::ACTIVE_CYCLES)) begin
      if (hcount == 11'(vpo_pkg::LINE_CYCLES - 4 - vpo_pkg::ACTIVE_CYCLES)) begin
        next_out_byte = 8'hff;
      end else if (hcount == 11'(vpo_pkg::LINE_CYCLES - 1 - vpo_pkg::ACTIVE_CYCLES)) begin
        next_out_byte = trs(field, vblank, 1'b0);
      end else begin
        next_out_byte = 8'h00;
      end
    end else if (hcount >= 11'(vpo_pkg::LINE_CYCLES - vpo_pkg::ACTIVE_CYCLES)) begin
      case (fmt)
        vpo_pkg::FMT_YUV: begin
          next_out_byte = sources.yuv;
          next_tl_out = (line_code == vpo_pkg::TYPE_TEST);
        end
        vpo_pkg::FMT_SLICED: next_out_byte = sources.sliced_valid ? sources.sliced : vpo_pkg::NO_DATA;
        vpo_pkg::FMT_RAW: begin
          if (hcount >= raw_start && hcount < raw_end) next_out_byte = sources.raw;
        end
        default: next_out_byte = vpo_pkg::NO_DATA;
      endcase
    end
  end

  // Reset starts at the first EAV preamble byte of line one, so the first line out is always framed.
  // The V flag resets high so a receiver treats that first line as blanking.
  always_ff @(posedge line_locked_clock) begin
    if (link_rst) begin
      hcount <= 11'd0;
      line <= 10'd1;
      field <= 1'b0;
      vblank <= 1'b1;
      line_vref <= 1'b1;
      line_code <= 4'h0;
      out_byte <= vpo_pkg::BLANK_A;
      tl_out <= 1'b0;
    end else begin
      hcount <= next_hcount;
      line <= next_line;
      field <= next_field;
      vblank <= next_vblank;
      line_vref <= next_line_vref;
      line_code <= next_line_code;
      out_byte <= next_out_byte;
      tl_out <= next_tl_out;
    end
  end

  // Both outputs are plain copies of flops, so the port never glitches mid-cycle.
  // A receiver may therefore sample on either half of the line clock.
  assign video_port_output = out_byte;
  assign test_line_active = tl_out;

  a_blank_pair: assert property (@(posedge line_locked_clock) disable iff (link_rst)
    (!cfg_s2.bypass && hcount == 11'd10) |=> (out_byte == vpo_pkg::BLANK_A))
    else $error("Blanking byte wrong.");

  a_code_msb: assert property (@(posedge line_locked_clock) disable iff (link_rst)
    (!cfg_s2.bypass && hcount == 11'd3) |=> out_byte[7])
    else $error("Timing code bit 7 not set.");

  a_eav_hbit: assert property (@(posedge line_locked_clock) disable iff (link_rst)
    (!cfg_s2.bypass && hcount == 11'd3) |=> out_byte[4])
    else $error("End code H bit low.");

  a_fv_hold: assert property (@(posedge line_locked_clock) disable iff (link_rst)
    (hcount != 11'd4) |-> ($stable(field) && $stable(vblank)))
    else $error("F or V changed away from end code.");

  a_sav_hbit: assert property (@(posedge line_locked_clock) disable iff (link_rst)
    (!cfg_s2.bypass && hcount == 11'(vpo_pkg::LINE_CYCLES - 1 - vpo_pkg::ACTIVE_CYCLES))
    |=> !out_byte[4]) else $error("Start code H bit high.");

  a_code_lead: assert property (@(posedge line_locked_clock) disable iff (link_rst)
    (!cfg_s2.bypass && hcount == 11'd0) |=> (out_byte == 8'hff))
    else $error("Code preamble does not start with ff.");

  a_blank_odd: assert property (@(posedge line_locked_clock) disable iff (link_rst)
    (!cfg_s2.bypass && hcount == 11'd11) |=> (out_byte == vpo_pkg::BLANK_B))
    else $error("Second blanking byte wrong.");

  a_line_wrap: assert property (@(posedge line_locked_clock) disable iff (link_rst)
    (hcount == 11'(vpo_pkg::LINE_CYCLES - 1)) |=> (hcount == 11'd0))
    else $error("Line length wrong.");

  a_test_vref: assert property (@(posedge line_locked_clock) disable iff (link_rst)
    tl_out |-> !line_vref)
    else $error("Test line sent on a reference line.");

  a_sliced_fill: assert property (@(posedge line_locked_clock) disable iff (link_rst)
    (!cfg_s2.bypass && hcount >= 11'(vpo_pkg::LINE_CYCLES - vpo_pkg::ACTIVE_CYCLES)
     && fmt == vpo_pkg::FMT_SLICED && !sources.sliced_valid) |=> (out_byte == vpo_pkg::NO_DATA))
    else $error("Empty sliced cycle not zero.");

  a_bypass_byte: assert property (@(posedge line_locked_clock) disable iff (link_rst)
    (cfg_s2.bypass && !cfg_s2.yc_mode && cfg_s2.align_hi)
    |=> (out_byte == $past(sources.adc_a[8:1]))) else $error("Bypass upper byte wrong.");
endmodule
`default_nettype wire

// ---- test/capture_sink_model.sv ----
/*
  Behavioural model of the capture logic that receives the video port output.
  Assumes the port changes on the rising edge of the line clock and that the
  timing code preamble is the three bytes ff, 00, 00.
*/
`timescale 1ns/1ps
`default_nettype none
module capture_sink_model (
  input  wire logic        line_locked_clock,
  input  wire logic        link_rst,
  input  wire logic [7:0]  video_port_output,
  input  wire logic [7:0]  expect_byte,
  output logic      [15:0] line_count,
  output logic      [15:0] code_total,
  output logic      [7:0]  eav_code,
  output logic      [7:0]  sav_code,
  output logic      [15:0] active_len,
  output logic      [15:0] active_match,
  output logic      [15:0] blank_bad
);
  logic [23:0] hist;
  logic [15:0] run_len;
  logic [15:0] run_match;
  logic        in_active;
  logic        in_blank;
  logic        want_first;

  // A real receiver only knows where a line is from the codes, so the model
  // measures the active region from SAV to the next preamble start.
  always_ff @(posedge line_locked_clock) begin
    if (link_rst) begin
      hist       <= 24'h0;
      {line_count, code_total, active_len, active_match, blank_bad} <= '0;
      {eav_code, sav_code, run_len, run_match} <= '0;
      {in_active, in_blank, want_first} <= 3'b000;
    end else begin
      hist <= {hist[15:0], video_port_output};
      if (hist == 24'hff0000 && video_port_output[7] && !in_active && !in_blank) begin
        code_total <= code_total + 16'h1;
        if (video_port_output[4]) begin
          eav_code     <= video_port_output;
          line_count   <= line_count + 16'h1;
          active_len   <= run_len;
          active_match <= run_match;
          in_blank     <= 1'b1;
          want_first   <= 1'b1;
        end else begin
          sav_code  <= video_port_output;
          in_active <= 1'b1;
          run_len   <= 16'h0;
          run_match <= 16'h0;
        end
      end else if (video_port_output == 8'hff) begin
        in_active <= 1'b0;
        in_blank  <= 1'b0;
      end else if (in_active) begin
        run_len <= run_len + 16'h1;
        if (video_port_output === expect_byte) begin
          run_match <= run_match + 16'h1;
        end
      end else if (in_blank) begin
        if (video_port_output !== (want_first ? 8'h80 : 8'h10)) begin
          blank_bad <= blank_bad + 16'h1;
        end
        want_first <= !want_first;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/video_port_output_formatter_tb.sv ----
/*
  Self-checking testbench of the video port output formatter.
  Assumes a 100 MHz register clock, a 64 ns line clock and the capture model.
*/
`timescale 1ns/1ps
`default_nettype none
module video_port_output_formatter_tb;
  logic                 clk;
  logic                 sys_rst;
  logic                 reg_write;
  logic [7:0]           reg_addr;
  logic [7:0]           reg_wdata;
  logic [7:0]           reg_rdata;
  logic                 line_locked_clock;
  logic                 link_rst;
  vpo_pkg::sources_type sources;
  logic [7:0]           video_port_output;
  logic                 test_line_active;
  logic                 test_line_luma_bypass;
  logic [7:0]           expect_byte;
  logic [15:0]          line_count;
  logic [15:0]          code_total;
  logic [15:0]          codes_before;
  logic [7:0]           eav_code;
  logic [7:0]           sav_code;
  logic [15:0]          active_len;
  logic [15:0]          active_match;
  logic [15:0]          blank_bad;
  int                   err_total;
  int                   tests_run;

  video_port_output_formatter i_dut (.clk(clk), .sys_rst(sys_rst), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .line_locked_clock(line_locked_clock), .link_rst(link_rst), .lines_625(1'b1),
    .sources(sources), .video_port_output(video_port_output),
    .test_line_active(test_line_active), .test_line_luma_bypass(test_line_luma_bypass));

  capture_sink_model i_sink (.line_locked_clock(line_locked_clock), .link_rst(link_rst),
    .video_port_output(video_port_output), .expect_byte(expect_byte),
    .line_count(line_count), .code_total(code_total), .eav_code(eav_code),
    .sav_code(sav_code), .active_len(active_len), .active_match(active_match),
    .blank_bad(blank_bad));

  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end

  // The line clock is offset so that its edges drift against the register clock.
  initial begin
    line_locked_clock = 1'b0;
    #7;
    forever #32 line_locked_clock = !line_locked_clock;
  end

  task automatic tally_and_finish;
    $display("mismatches %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_write = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_write = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 reg_addr = a;
    @(posedge clk);
    #1 chk({8'h00, reg_rdata}, {8'h00, exp}, "register read");
  endtask

  task automatic fill_table(input logic [7:0] d);
    for (int i = 0; i < 23; i++) begin
      wr(vpo_pkg::OFS_LINE_TYPE_FIRST + 8'(i), d);
    end
  endtask

  // The first line after a change may be partly old, so later lines are judged.
  task automatic wait_lines(input int n);
    logic [15:0] start;
    int          k;
    start = line_count;
    k = 0;
    while (line_count != start + 16'(n) && k < 14000 * n) begin
      @(posedge clk);
      k++;
    end
    if (k >= 14000 * n) begin
      err_total++;
      $display("wrong value at %0t: no line end seen", $time);
      tally_and_finish();
    end
  endtask

  task automatic port_hold(input logic [7:0] exp);
    int bad;
    bad = 0;
    repeat (60) @(posedge clk);
    repeat (300) begin
      @(posedge clk);
      if (video_port_output !== exp) bad++;
    end
    chk(16'(bad), 16'h0, "bypass byte");
  endtask

  initial begin
    err_total = 0;
    tests_run = 0;
    sys_rst   = 1'b1;
    link_rst  = 1'b1;
    reg_write = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    expect_byte = 8'h55;
    sources.yuv          = 8'h55;
    sources.sliced       = 8'h00;
    sources.sliced_valid = 1'b0;
    sources.raw          = 8'h33;
    sources.adc_a        = 9'h155;
    sources.adc_b        = 9'h155;
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    // The line logic needs several reset edges so history checks start clean.
    repeat (4) @(posedge line_locked_clock);
    @(posedge clk);
    #1 link_rst = 1'b0;
    wr(vpo_pkg::OFS_FORMAT, 8'h80);
    wr(vpo_pkg::OFS_VOFF_LO, 8'h07);
    wr(vpo_pkg::OFS_VOFF_HI, 8'h00);
    wr(vpo_pkg::OFS_MODE, 8'h00);
    wr(vpo_pkg::OFS_BYPASS, 8'h00);
    wr(vpo_pkg::OFS_ADC_ALIGN, 8'h80);
    fill_table(8'hff);
    rd_chk(vpo_pkg::OFS_LINE_TYPE_FIRST, 8'hff);
    rd_chk(vpo_pkg::OFS_LINE_TYPE_LAST, 8'hff);
    wait_lines(3);
    chk(active_len, 16'd1440, "active length");
    chk(active_match, 16'd1440, "yuv bytes");
    chk(blank_bad, 16'h0, "blanking bytes");
    chk({12'h0, eav_code[7:4]}, 16'h9, "eav flags");
    chk({12'h0, sav_code[7:4]}, 16'h8, "sav flags");
    // Field one reads the upper nibble, so 0f selects sliced there.
    expect_byte = 8'h00;
    fill_table(8'h0f);
    wait_lines(3);
    chk(active_len, 16'd1440, "sliced length");
    chk(active_match, 16'd1440, "empty sliced bytes");
    chk({12'h0, sav_code[7:4]}, 16'ha, "sliced sav flags");
    chk({12'h0, eav_code[7:4]}, 16'hb, "sliced eav flags");
    chk(blank_bad, 16'h0, "blanking bytes");
    chk({15'h0, test_line_active}, 16'h0, "test line flag");
    wr(vpo_pkg::OFS_LUMA_BYPASS, 8'h80);
    repeat (2) @(posedge clk);
    #1 chk({15'h0, test_line_luma_bypass}, 16'h1, "luma bypass");
    wr(vpo_pkg::OFS_BYPASS, 8'h02);
    repeat (20) @(posedge clk);
    codes_before = code_total;
    port_hold(8'haa);
    wr(vpo_pkg::OFS_ADC_ALIGN, 8'h00);
    port_hold(8'h55);
    chk(code_total, codes_before, "codes in bypass");
    tally_and_finish();
  end
endmodule
`default_nettype wire
